// *** dv/ppc_port_cfg_checker.sv ***
// Checker for register writes and pin mode decoding
`default_nettype none
module ppc_port_cfg_checker (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic [7:0] reg_addr, // Address
  input wire logic reg_wr, // Write
  input wire logic [7:0] reg_wdata, // Data
  input wire logic [6:0] pin_oe, // Drive
  input wire logic [6:0] lcd_seg_en, // Segment
  input wire logic [7:0] cfg_low, // Low config
  input wire logic [7:0] cfg_high // High config
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_lw; reg_wr && reg_addr == 8'hEF |=> cfg_low == $past(reg_wdata); endproperty
  a_lw: assert property (p_lw) else $error("low write");
  property p_hw; reg_wr && reg_addr == 8'hEE |=> cfg_high == {2'h0, $past(reg_wdata[5:0])};
  endproperty
  a_hw: assert property (p_hw) else $error("high write");
  property p_rst; $fell(rst) |-> cfg_low == 8'h00 && cfg_high == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_oe0; cfg_low[1:0] == 2'h1 |=> pin_oe[0]; endproperty
  a_oe0: assert property (p_oe0) else $error("pin0 output");
  property p_p1; cfg_low[3:2] == 2'h2 |=> !pin_oe[1]; endproperty
  a_p1: assert property (p_p1) else $error("pin1 unused code");
  property p_p4; cfg_high[1:0] == 2'h2 |=> !pin_oe[4] && !lcd_seg_en[4]; endproperty
  a_p4: assert property (p_p4) else $error("pin4 unused code");
  property p_l6; cfg_high[5:4] == 2'h3 |=> lcd_seg_en[6]; endproperty
  a_l6: assert property (p_l6) else $error("pin6 segment");
  // Guard avoids the edge right after a mid-run reset
  property p_l5; !$past(rst) |-> lcd_seg_en[5] == ($past(cfg_high[3:2]) == 2'h3); endproperty
  a_l5: assert property (p_l5) else $error("pin5 segment");
endmodule : ppc_port_cfg_checker
bind ppc_port_cfg ppc_port_cfg_checker i_chk (.*);
`default_nettype wire

// *** dv/tb_ppc_port_cfg.sv ***
// Self-checking bench for the port configuration block
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("BAD %0t %h %h", $time, a, e); end end
module tb_ppc_port_cfg;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, pending_clr = 8'h00;
  logic [7:0] reg_rdata, cfg_low, cfg_high, d;
  logic [6:0] pin_in = 7'h55, periph_out = 7'h2B, open_drain = 7'h00;
  logic [6:0] pin_out, pin_oe, lcd_seg_en, periph_in;
  logic [3:0] ext_pins = 4'h0, ext_pending;
  logic [23:0] rows [5] = '{24'hE8_A5A5, 24'hE9_FFFF, 24'hEE_FF3F, 24'hEF_C5C5, 24'h10_FF00};
  int mismatches = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  ppc_port_cfg i_dut (.*);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_addr = a;
    cyc(1);
    d = reg_rdata;
  endtask : rd
  // Clear pulse precedes each toggle so a stale flag cannot pass
  task automatic edge_chk(input int ln, input logic [7:0] a, input int sh);
    for (int c = 0; c < 4; c++) begin
      wr(a, 8'(c << sh));
      pending_clr = 8'hFF;
      cyc(1);
      pending_clr = 8'h00;
      ext_pins[ln] = 1'b1;
      cyc(4);
      `CHK(ext_pending[ln], c[1])
      pending_clr = 8'hFF;
      cyc(1);
      pending_clr = 8'h00;
      ext_pins[ln] = 1'b0;
      cyc(4);
      `CHK(ext_pending[ln], c[0])
    end
  endtask : edge_chk
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    cyc(2);
    rst = 1'b0;
    `CHK(pin_oe, 7'h00)
    for (int i = 1; i < 4; i++) begin
      rd(rows[i][23:16]);
      `CHK(d, 8'h00)
    end
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      `CHK(d, rows[i][7:0])
    end
    edge_chk(0, 8'hE8, 2);
    edge_chk(1, 8'hE9, 4);
    edge_chk(2, 8'hE9, 6);
    edge_chk(3, 8'hE8, 6);
    wr(8'hEE, 8'h3A);
    wr(8'hEF, 8'h5A);
    wr(8'hF4, 8'h0A);
    cyc(2);
    `CHK(lcd_seg_en[6:4], 3'h4)
    `CHK(pin_oe[5:0], 6'h2D)
    `CHK({pin_out[5], pin_out[3:2], pin_out[0]}, 4'hD)
    `CHK(periph_in[6:4], 3'h1)
    rd(8'hF4);
    `CHK({d[7], d[3:1]}, 4'h4)
    open_drain = 7'h0C;
    cyc(2);
    `CHK(pin_oe[3:2], 2'h1)
    open_drain = 7'h00;
    wr(8'hE8, 8'h08);
    ext_pins[0] = 1'b1;
    pending_clr = 8'hFF;
    cyc(1);
    pending_clr = 8'h00;
    `CHK(ext_pending[0], 1'b1)
    rd(8'hF6);
    `CHK(d, 8'h01)
    rst = 1'b1;
    cyc(1);
    rst = 1'b0;
    `CHK({cfg_high, cfg_low}, 16'h0000)
    finish_test();
  end
  initial begin
    #20000;
    mismatches++;
    finish_test();
  end
endmodule : tb_ppc_port_cfg
`default_nettype wire

// *** rtl/ppc_pkg.sv ***
// Types for the port configuration and external interrupt edge block
`default_nettype none
package ppc_pkg;
  typedef enum logic [1:0] {
    PPC_EDGE_OFF = 2'h0,
    PPC_EDGE_FALL = 2'h1,
    PPC_EDGE_RISE = 2'h2,
    PPC_EDGE_BOTH = 2'h3
  } ppc_edge_t;
  typedef enum logic [1:0] {
    PPC_PIN_INPUT = 2'h0,
    PPC_PIN_OUTPUT = 2'h1,
    PPC_PIN_ALT = 2'h2,
    PPC_PIN_LCD = 2'h3
  } ppc_pin_mode_t;
endpackage : ppc_pkg
`default_nettype wire

// *** rtl/ppc_port_cfg.sv ***
// Port pin configuration, data register and external interrupt edge detection
`include "ppc_regs.svh"
`default_nettype none
module ppc_port_cfg (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] reg_addr, // Register file address
  input wire logic reg_wr, // Write strobe
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic [7:0] pending_clr, // Pulse per bit to clear a pending flag
  output logic [7:0] reg_rdata, // Registered read data
  input wire logic [6:0] pin_in, // Port 4 pad levels
  output logic [6:0] pin_out, // Port 4 pad drive level
  output logic [6:0] pin_oe, // Port 4 pad drive enable
  input wire logic [6:0] open_drain, // Per pin open-drain select
  input wire logic [3:0] ext_pins, // Port 3 pins 1,5,6 and port 0 pin 3
  output logic [3:0] ext_pending, // Pending flags per external line
  output logic [6:0] lcd_seg_en, // Pin handed to the LCD segment driver
  output logic [6:0] periph_in, // Pin level routed to its peripheral input
  input wire logic [6:0] periph_out, // Peripheral output per pin
  output logic [7:0] cfg_low, // Low config register
  output logic [7:0] cfg_high // High config register
);
  logic [7:0] edge_high_q, edge_high_d;
  logic [7:0] edge_low_q, edge_low_d;
  logic [7:0] cfg_high_q, cfg_high_d;
  logic [7:0] cfg_low_q, cfg_low_d;
  logic [6:0] levels_q, levels_d;
  logic [3:0] ext_prev_q;
  logic [3:0] pend_q, pend_d;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic [6:0] out_q, oe_q, lcd_q, pin_in_q;
  logic [6:0] out_d, oe_d, lcd_d;
  logic [6:0] periph_q, periph_d;

  // One code decoder shared by all four lines

  function automatic logic edge_hit(input logic [1:0] code, input logic prev, input logic cur);
    ppc_pkg::ppc_edge_t e;
    e = ppc_pkg::ppc_edge_t'(code);
    case (e)
      ppc_pkg::PPC_EDGE_FALL: edge_hit = prev & ~cur;
      ppc_pkg::PPC_EDGE_RISE: edge_hit = ~prev & cur;
      ppc_pkg::PPC_EDGE_BOTH: edge_hit = prev ^ cur;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  function automatic logic [1:0] pin_code(input logic [7:0] lo, input logic [7:0] hi, input int p);
    logic [15:0] all;
    all = {hi, lo};
    pin_code = all[2*p +: 2];
  endfunction : pin_code

  // Two-bit field of a byte at a given low bit position
  function automatic logic [1:0] field2(input logic [7:0] b, input int lsb);
    field2 = b[lsb +: 2];
  endfunction : field2

  wire sel_eh = reg_addr == `PPC_ADDR_EDGE_HIGH;
  wire sel_el = reg_addr == `PPC_ADDR_EDGE_LOW;
  wire sel_ch = reg_addr == `PPC_ADDR_CFG_HIGH;
  wire sel_cl = reg_addr == `PPC_ADDR_CFG_LOW;
  wire sel_lv = reg_addr == `PPC_ADDR_LEVELS;
  wire sel_pd = reg_addr == `PPC_ADDR_PENDING;

  // Write enables per register
  wire wr_eh = reg_wr && sel_eh;
  wire wr_el = reg_wr && sel_el;
  wire wr_ch = reg_wr && sel_ch;
  wire wr_cl = reg_wr && sel_cl;
  wire wr_lv = reg_wr && sel_lv;

  assign edge_high_d = wr_eh ? reg_wdata : edge_high_q;
  assign edge_low_d = wr_el ? reg_wdata : edge_low_q;
  // Mask keeps the reserved high bits reading zero
  assign cfg_high_d = wr_ch ? (reg_wdata & `PPC_CFG_HIGH_MASK) : cfg_high_q;
  assign cfg_low_d = wr_cl ? reg_wdata : cfg_low_q;
  assign levels_d = wr_lv ? reg_wdata[`PPC_PINS-1:0] : levels_q;

  // Line order: 0 = port3 pin1, 1 = port3 pin5, 2 = port3 pin6, 3 = port0 pin3
  wire [3:0] ext_hit;
  assign ext_hit[0] = edge_hit(field2(edge_high_q, `PPC_FLD_P31), ext_prev_q[0], ext_pins[0]);
  assign ext_hit[1] = edge_hit(field2(edge_low_q, `PPC_FLD_P35), ext_prev_q[1], ext_pins[1]);
  assign ext_hit[2] = edge_hit(field2(edge_low_q, `PPC_FLD_P36), ext_prev_q[2], ext_pins[2]);
  assign ext_hit[3] = edge_hit(field2(edge_high_q, `PPC_FLD_P03), ext_prev_q[3], ext_pins[3]);
  // Set wins over clear so an edge in the clear cycle is kept
  assign pend_d = ext_hit | (pend_q & ~pending_clr[3:0]);

  // Reading the data register shows the latch for driven pins, pad level for undriven ones (open-drain high included)
  wire [6:0] level_view = (oe_q & levels_q) | (~oe_q & pin_in_q);
  wire [6:0] no_alt_out = `PPC_NO_ALT_OUT;
  always_comb begin
    rdata_d = `PPC_ZERO_BYTE;
    if (sel_eh) rdata_d = edge_high_q;
    if (sel_el) rdata_d = edge_low_q;
    if (sel_ch) rdata_d = cfg_high_q;
    if (sel_cl) rdata_d = cfg_low_q;
    if (sel_lv) rdata_d = {1'b0, level_view};
    if (sel_pd) rdata_d = {4'h0, pend_q};
  end

  always_comb begin
    ppc_pkg::ppc_pin_mode_t m;
    m = ppc_pkg::PPC_PIN_INPUT;
    out_d = '0;
    oe_d = '0;
    lcd_d = '0;
    for (int p = 0; p < `PPC_PINS; p++) begin
      m = ppc_pkg::ppc_pin_mode_t'(pin_code(cfg_low_q, cfg_high_q, p));
      case (m)
        ppc_pkg::PPC_PIN_OUTPUT: begin
          // Open drain drives only the low level
          out_d[p] = levels_q[p];
          oe_d[p] = open_drain[p] ? ~levels_q[p] : 1'b1;
        end
        ppc_pkg::PPC_PIN_ALT: begin
          // Pins 1, 4 and 6 have no output alternative: stay input
          if (!no_alt_out[p]) begin
            out_d[p] = periph_out[p];
            oe_d[p] = open_drain[p] ? ~periph_out[p] : 1'b1;
          end
        end
        ppc_pkg::PPC_PIN_LCD: lcd_d[p] = 1'b1;
        default: ;
      endcase
    end
  end

  // Same timing as masking the sampled pad with the drive flops
  assign periph_d = pin_in & ~oe_d & ~lcd_d;

  // Configuration and data registers
  always_ff @(posedge clk) begin
    if (rst) begin
      edge_high_q <= `PPC_RST_EDGE;
      edge_low_q <= `PPC_RST_EDGE;
      cfg_high_q <= `PPC_RST_CFG;
      cfg_low_q <= `PPC_RST_CFG;
      levels_q <= `PPC_RST_LEVELS;
    end else begin
      edge_high_q <= edge_high_d;
      edge_low_q <= edge_low_d;
      cfg_high_q <= cfg_high_d;
      cfg_low_q <= cfg_low_d;
      levels_q <= levels_d;
    end
  end

  // Edge history and sticky pending flags
  // Prev resets low, but edge codes reset to off, so a pin high at reset gives no event
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= '0;
      ext_prev_q <= '0;
    end else begin
      pend_q <= pend_d;
      ext_prev_q <= ext_pins;
    end
  end

  // Registered read: data follows the address by one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= `PPC_ZERO_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Pad drive, segment hand-over and peripheral view
  always_ff @(posedge clk) begin
    if (rst) begin
      out_q <= '0;
      oe_q <= '0;
      lcd_q <= '0;
      periph_q <= '0;
      pin_in_q <= '0;
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
      lcd_q <= lcd_d;
      periph_q <= periph_d;
      pin_in_q <= pin_in;
    end
  end

  assign reg_rdata = rdata_q;
  assign pin_out = out_q;
  assign pin_oe = oe_q;
  assign lcd_seg_en = lcd_q;
  // Peripheral must still be enabled in its own module to use this
  assign periph_in = periph_q;
  assign ext_pending = pend_q;
  assign cfg_low = cfg_low_q;
  assign cfg_high = cfg_high_q;
endmodule : ppc_port_cfg
`default_nettype wire

// *** rtl/ppc_regs.svh ***
// Register offsets, field positions and reset values of the port configuration block
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH
`define PPC_ADDR_EDGE_HIGH 8'hE8
`define PPC_ADDR_EDGE_LOW 8'hE9
`define PPC_ADDR_CFG_HIGH 8'hEE
`define PPC_ADDR_CFG_LOW 8'hEF
`define PPC_ADDR_LEVELS 8'hF4
`define PPC_ADDR_PENDING 8'hF6
`define PPC_RST_EDGE 8'h00
`define PPC_RST_CFG 8'h00
`define PPC_RST_LEVELS 7'h00
`define PPC_CFG_HIGH_MASK 8'h3F
`define PPC_ZERO_BYTE 8'h00
`define PPC_LINES 5
`define PPC_PINS 7
`define PPC_FLD_P31 2
`define PPC_FLD_P35 4
`define PPC_FLD_P36 6
`define PPC_FLD_P03 6
`define PPC_NO_ALT_OUT 7'h52
`endif
